//--- inc/arssc_params.svh
// constants for the read, verify, seek and sense command block
`ifndef ARSSC_PARAMS_SVH
`define ARSSC_PARAMS_SVH
// command codes
`define ARSSC_CMD_READ0 8'h20
`define ARSSC_CMD_READ1 8'h21
`define ARSSC_CMD_VERIFY0 8'h40
`define ARSSC_CMD_VERIFY1 8'h41
`define ARSSC_CMD_SENSE 8'h03
`define ARSSC_NIB_RECAL 4'h1
`define ARSSC_NIB_SEEK 4'h7
// extended error codes
`define ARSSC_EXT_NONE 8'h00
`define ARSSC_EXT_BAD_ADDR 8'h21
`define ARSSC_EXT_OVERFLOW 8'h2f
`define ARSSC_EXT_UNCORR 8'h11
`define ARSSC_EXT_CORR 8'h18
`define ARSSC_EXT_XFER 8'h1f
`define ARSSC_EXT_DIAG 8'h05
`define ARSSC_EXT_SPARE 8'h3a
// sizes and reset values
`define ARSSC_SEC_MAX 9'h100
`define ARSSC_WORD_LAST 8'hff
`define ARSSC_RST_BYTE 8'h00
`endif

//--- inc/arssc_pkg.sv
// types shared by the read, verify, seek and sense command block
package arssc_pkg;
   // task-file contents written by the host
   typedef struct packed {
      logic lba_mode;
      logic [3:0] head;
      logic [7:0] cyl_hi;
      logic [7:0] cyl_lo;
      logic [7:0] sec_num;
      logic [7:0] sec_cnt;
   } arssc_tf_type;
   // outcome of one media sector fetch
   typedef enum logic [2:0] {
      ARSSC_MS_OK = 3'h0,
      ARSSC_MS_CORR = 3'h1,
      ARSSC_MS_UNCORR = 3'h2,
      ARSSC_MS_XFER = 3'h3,
      ARSSC_MS_SPARE = 3'h4,
      ARSSC_MS_DIAG = 3'h5
   } arssc_mstat_type;
   typedef enum logic [2:0] {
      ARSSC_IDLE = 3'b001,
      ARSSC_FETCH = 3'b010,
      ARSSC_XFER = 3'b100
   } arssc_state_type;
endpackage

//--- design/arssc_core.sv
// card-side executor for read, read-verify, recalibrate, sense and seek
`timescale 1ns/100ps
`include "arssc_params.svh"

// Functional notes
// - read codes, count zero means 256
// - read starts at task-file address
// - bsy, load, drq, drop bsy, interrupt
// - read error stops, keeps address, data
// - lba 27-24 in head, rest in bytes
// - verify acts as read, never drq
// - verify sets bsy, one final interrupt
// - failed verify leaves address, remaining count
// - recalibrate family is a no-op
// - sense copies extended code to error
// - codes 00h, 21h, 2fh for address
// - codes 11h, 18h, 1fh for data
// - diagnostic 05h, spares exhausted 3ah
// - seek only range-checks the address
module arssc_core (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_wr,
   input wire logic [7:0] cmd_code,
   input wire arssc_pkg::arssc_tf_type tf_in,
   input wire logic word_rd,
   input wire logic status_rd,
   input wire logic [27:0] capacity,
   input wire logic [4:0] num_heads,
   input wire logic [7:0] sec_per_trk,
   input wire logic media_done,
   input wire arssc_pkg::arssc_mstat_type media_stat,
   output logic media_req,
   output logic [27:0] media_lba,
   output logic bsy,
   output logic drq,
   output logic intrq,
   output logic err,
   output logic [7:0] error_reg,
   output arssc_pkg::arssc_tf_type tf_out
);
   import arssc_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   arssc_state_type state_q, state_d;
   logic lba_mode_q;
   logic [3:0] head_q;
   logic [15:0] cyl_q;
   logic [7:0] sec_q;
   logic [8:0] remain_q;
   logic verify_q;
   logic stop_q;
   logic [7:0] word_q;
   logic [7:0] ext_q;
   logic [7:0] err_reg_q;
   logic err_q;
   logic intrq_q;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   wire idle = (state_q == ARSSC_IDLE);
   wire take = cmd_wr & idle;
   wire is_read = (cmd_code == `ARSSC_CMD_READ0) | (cmd_code == `ARSSC_CMD_READ1);
   wire is_ver = (cmd_code == `ARSSC_CMD_VERIFY0) | (cmd_code == `ARSSC_CMD_VERIFY1);
   wire is_recal = (cmd_code[7:4] == `ARSSC_NIB_RECAL);
   wire is_seek = (cmd_code[7:4] == `ARSSC_NIB_SEEK);
   wire is_sense = (cmd_code == `ARSSC_CMD_SENSE);
   wire start_rd = take & (is_read | is_ver);

   // ----------------------------------------
   // address forming and range check
   // ----------------------------------------
   // the seek checks the freshly written task file, media work the held copy
   wire use_in = take & is_seek;
   wire a_lba = use_in ? tf_in.lba_mode : lba_mode_q;
   wire [3:0] a_head = use_in ? tf_in.head : head_q;
   wire [15:0] a_cyl = use_in ? {tf_in.cyl_hi, tf_in.cyl_lo} : cyl_q;
   wire [7:0] a_sec = use_in ? tf_in.sec_num : sec_q;
   // chs to block: ((cyl * heads) + head) * spt + sec - 1
   wire [20:0] chs_trk = 21'(a_cyl * num_heads) + 21'(a_head);
   wire [28:0] chs_blk = 29'(chs_trk * sec_per_trk) + 29'(a_sec) - 29'h1;
   wire [27:0] lba_addr = {a_head, a_cyl, a_sec};
   wire [27:0] addr = a_lba ? lba_addr : chs_blk[27:0];
   wire chs_bad = ~a_lba & ((a_sec == 8'h00) | (a_sec > sec_per_trk) | ({1'b0, a_head} >= num_heads));
   // an underflowed chs sum is caught by chs_bad first
   wire ovf = (addr >= capacity) | (~a_lba & chs_blk[28]);
   wire range_ok = ~chs_bad & ~ovf;
   wire [7:0] range_code = chs_bad ? `ARSSC_EXT_BAD_ADDR : `ARSSC_EXT_OVERFLOW;

   // ----------------------------------------
   // media outcome decode
   // ----------------------------------------
   wire fetch = (state_q == ARSSC_FETCH);
   wire fetch_bad = fetch & ~range_ok;
   wire got = fetch & range_ok & media_done;
   wire m_ok = (media_stat == ARSSC_MS_OK) | (media_stat == ARSSC_MS_CORR);
   // a corrected sector is good data, so the command keeps going
   wire [7:0] m_code = (media_stat == ARSSC_MS_OK) ? `ARSSC_EXT_NONE :
                       (media_stat == ARSSC_MS_CORR) ? `ARSSC_EXT_CORR :
                       (media_stat == ARSSC_MS_UNCORR) ? `ARSSC_EXT_UNCORR :
                       (media_stat == ARSSC_MS_SPARE) ? `ARSSC_EXT_SPARE :
                       (media_stat == ARSSC_MS_DIAG) ? `ARSSC_EXT_DIAG :
                       `ARSSC_EXT_XFER;
   wire last = (remain_q == 9'h001);
   wire xfer = (state_q == ARSSC_XFER);
   wire sec_end = xfer & word_rd & (word_q == `ARSSC_WORD_LAST);
   // advance after a good sector that is not the last one
   wire adv = (sec_end & ~stop_q & ~last) | (got & verify_q & m_ok & ~last);
   wire seek_bad = take & is_seek & ~range_ok;

   // ----------------------------------------
   // next address: lba counts up, chs wraps sector, head, cylinder
   // ----------------------------------------
   wire [27:0] lba_next = lba_addr + 28'h1;
   wire sec_wrap = (sec_q == sec_per_trk);
   wire head_wrap = ({1'b0, head_q} == (num_heads - 5'h1));
   wire [7:0] chs_sec_n = sec_wrap ? 8'h01 : sec_q + 8'h01;
   wire [3:0] chs_head_n = ~sec_wrap ? head_q : (head_wrap ? 4'h0 : head_q + 4'h1);
   wire [15:0] chs_cyl_n = (sec_wrap & head_wrap) ? cyl_q + 16'h0001 : cyl_q;

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ARSSC_IDLE: begin
            if (start_rd) begin
               state_d = ARSSC_FETCH;
            end
         end
         ARSSC_FETCH: begin
            if (fetch_bad) begin
               state_d = ARSSC_IDLE;
            end else if (got & ~verify_q) begin
               state_d = ARSSC_XFER;
            end else if (got & (~m_ok | last)) begin
               state_d = ARSSC_IDLE;
            end
         end
         ARSSC_XFER: begin
            if (sec_end) begin
               state_d = (stop_q | last) ? ARSSC_IDLE : ARSSC_FETCH;
            end
         end
         default: begin
            state_d = ARSSC_IDLE;
         end
      endcase
   end

   // one interrupt per sector for reads, one at the end for the rest
   wire intr_set = (got & ~verify_q) | (got & verify_q & (~m_ok | last)) | fetch_bad
                   | (take & (is_recal | is_seek | is_sense));
   wire err_set = fetch_bad | (got & ~m_ok) | seek_bad;
   wire err_clr = take & ~is_sense;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ARSSC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // task-file copy: loaded at start, advanced only after good sectors
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lba_mode_q <= 1'b0;
         head_q <= 4'h0;
         cyl_q <= 16'h0000;
         sec_q <= `ARSSC_RST_BYTE;
         remain_q <= 9'h000;
         verify_q <= 1'b0;
      end else if (take) begin
         lba_mode_q <= tf_in.lba_mode;
         head_q <= tf_in.head;
         cyl_q <= {tf_in.cyl_hi, tf_in.cyl_lo};
         sec_q <= tf_in.sec_num;
         remain_q <= (tf_in.sec_cnt == 8'h00) ? `ARSSC_SEC_MAX : {1'b0, tf_in.sec_cnt};
         verify_q <= is_ver;
      end else if (adv) begin
         lba_mode_q <= lba_mode_q;
         head_q <= lba_mode_q ? lba_next[27:24] : chs_head_n;
         cyl_q <= lba_mode_q ? lba_next[23:8] : chs_cyl_n;
         sec_q <= lba_mode_q ? lba_next[7:0] : chs_sec_n;
         remain_q <= remain_q - 9'h001;
      end
   end

   // word count within the sector, and the stop mark after a failure
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_q <= 8'h00;
         stop_q <= 1'b0;
      end else begin
         word_q <= got ? 8'h00 : ((xfer & word_rd) ? word_q + 8'h01 : word_q);
         stop_q <= got ? ~m_ok : stop_q;
      end
   end

   // extended code of the latest command, and the error register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_q <= `ARSSC_EXT_NONE;
         err_reg_q <= `ARSSC_RST_BYTE;
      end else begin
         if (fetch_bad | seek_bad) begin
            ext_q <= range_code;
         end else if (got & (media_stat != ARSSC_MS_OK)) begin
            ext_q <= m_code;
         end else if (err_clr) begin
            ext_q <= `ARSSC_EXT_NONE;
         end
         if (take & is_sense) begin
            err_reg_q <= ext_q;
         end
      end
   end

   // interrupt is cleared by a status read; a new event wins the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_q <= 1'b0;
         intrq_q <= 1'b0;
      end else begin
         err_q <= err_set | (err_q & ~err_clr);
         intrq_q <= intr_set | (intrq_q & ~status_rd);
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign bsy = fetch;
   assign drq = xfer;
   assign media_req = fetch & range_ok;
   assign media_lba = addr;
   assign intrq = intrq_q;
   assign err = err_q;
   assign error_reg = err_reg_q;
   assign tf_out = '{lba_mode: lba_mode_q, head: head_q, cyl_hi: cyl_q[15:8], cyl_lo: cyl_q[7:0],
                     sec_num: sec_q, sec_cnt: remain_q[7:0]};

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence seq_read_ok;
      got & ~verify_q & m_ok;
   endsequence
   sequence seq_fail;
      got & ~m_ok;
   endsequence
   sequence seq_next_sector;
      sec_end & ~stop_q & ~last;
   endsequence
   sequence seq_verify_more;
      got & verify_q & m_ok & ~last;
   endsequence

   AST_READ_READY: assert property (seq_read_ok |=> drq & ~bsy & intrq)
      else $error("sector ready without drq or interrupt");
   AST_VERIFY_NO_DRQ: assert property (verify_q |-> ~drq)
      else $error("drq raised during verify");
   AST_VERIFY_BSY: assert property (take & is_ver |=> bsy)
      else $error("verify did not raise bsy");
   AST_COUNT_ZERO: assert property (start_rd & (tf_in.sec_cnt == 8'h00) |=> remain_q == `ARSSC_SEC_MAX)
      else $error("zero count not taken as 256");
   AST_SENSE: assert property (take & is_sense |=> error_reg == $past(ext_q))
      else $error("sense did not return extended code");
   AST_RECAL: assert property (take & is_recal |=> ~bsy & intrq & ~err)
      else $error("recalibrate not a plain no-op");
   AST_FAIL_HOLD: assert property (seq_fail |=> (sec_q == $past(sec_q)) && (remain_q == $past(remain_q)))
      else $error("failed sector address or count moved");
   AST_READ_FAIL: assert property (seq_fail ##0 ~verify_q |=> drq & err & (ext_q != `ARSSC_EXT_NONE))
      else $error("read failure not reported with data");
   AST_UNCORR: assert property (got & (media_stat == ARSSC_MS_UNCORR) |=> ext_q == `ARSSC_EXT_UNCORR)
      else $error("uncorrectable code wrong");
   AST_SEEK_RANGE: assert property (seek_bad |=> err & intrq & ~bsy & (ext_q == $past(range_code)))
      else $error("seek out of range not reported");
   AST_OVF: assert property (fetch & ~chs_bad & ovf |=> ext_q == `ARSSC_EXT_OVERFLOW && ~bsy)
      else $error("overflow code wrong");
   AST_NEXT_SECTOR: assert property (seq_next_sector |=> bsy & ~drq)
      else $error("next sector not loaded under bsy");
   AST_READ_END: assert property (sec_end & (stop_q | last) |=> ~bsy & ~drq)
      else $error("read did not stop after last or failing sector");
   AST_VERIFY_STEP: assert property (seq_verify_more |=> bsy & (remain_q == $past(remain_q) - 9'h001))
      else $error("verify did not move on to the next sector");
   AST_VERIFY_END: assert property (got & verify_q & m_ok & last |=> ~bsy & intrq & ~err)
      else $error("verify end without single interrupt");
   AST_VERIFY_FAIL: assert property (seq_fail ##0 verify_q |=> ~bsy & intrq & err)
      else $error("failed verify not ended with error");
   AST_BAD_ADDR: assert property (fetch & chs_bad |=> (ext_q == `ARSSC_EXT_BAD_ADDR) && err && ~bsy)
      else $error("invalid address code wrong");
   AST_CORR: assert property (got & (media_stat == ARSSC_MS_CORR) |=> (ext_q == `ARSSC_EXT_CORR) && ~err)
      else $error("corrected code wrong or flagged as error");
   AST_SEEK_OK: assert property (take & is_seek & range_ok |=> intrq & ~err & (ext_q == `ARSSC_EXT_NONE))
      else $error("seek in range did not complete cleanly");
endmodule

//--- test/arssc_media_model.sv
// media model answering sector loads after a fixed delay
`timescale 1ns/100ps
module arssc_media_model #(parameter int DLY = 3) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic media_req,
   input wire logic [27:0] media_lba,
   input wire logic [27:0] bad_lba,
   input wire arssc_pkg::arssc_mstat_type bad_stat,
   output logic media_done,
   output arssc_pkg::arssc_mstat_type media_stat
);
   import arssc_pkg::*;
   int cnt_q;
   logic [2:0] junk_q;
   // one done pulse per request, wait restarts after each pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 0;
         media_done <= 1'b0;
         junk_q <= 3'h0;
      end else begin
         junk_q <= junk_q + 3'h3;
         if (media_done) begin
            media_done <= 1'b0;
            cnt_q <= 0;
         end else if (media_req) begin
            cnt_q <= cnt_q + 1;
            media_done <= (cnt_q == DLY - 1);
         end else begin
            cnt_q <= 0;
         end
      end
   end
   // status wanders outside a done pulse so a stale sample is caught
   assign media_stat = !media_done ? arssc_mstat_type'(junk_q) : (media_lba == bad_lba) ? bad_stat : ARSSC_MS_OK;
endmodule

//--- test/ata_read_seek_sense_commands_tb.sv
// self-checking bench for the read, verify, seek and sense block
`timescale 1ns/100ps
module ata_read_seek_sense_commands_tb;
   import arssc_pkg::*;
   typedef struct {
      logic [7:0] code;
      arssc_tf_type tf;
      logic [27:0] bad;
      arssc_mstat_type st;
      int nf;
      int nd;
      int ni;
      logic er;
      logic [7:0] ext;
      logic [7:0] cnt;
   } arssc_row_type;
   localparam logic [27:0] NB = 28'hfffffff;
   logic clk, rst_n, cmd_wr, word_rd, status_rd, media_req, media_done, bsy, drq, intrq, err;
   logic [7:0] cmd_code, error_reg;
   logic [27:0] media_lba, bad_lba, lba0, lba1, exp_lba;
   arssc_tf_type tf_in, tf_out;
   arssc_mstat_type media_stat, bad_stat;
   int err_count, num_checks, nf, nd, ni, cyc;
   arssc_row_type rows [16];
   // geometry tied: 4096 blocks, 4 heads, 16 sectors per track
   arssc_core DUT (.clk(clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .tf_in(tf_in),
      .word_rd(word_rd), .status_rd(status_rd), .capacity(28'h0001000), .num_heads(5'h04),
      .sec_per_trk(8'h10), .media_done(media_done), .media_stat(media_stat), .media_req(media_req),
      .media_lba(media_lba), .bsy(bsy), .drq(drq), .intrq(intrq), .err(err), .error_reg(error_reg),
      .tf_out(tf_out));
   arssc_media_model #(.DLY(3)) media (.clk(clk), .rst_n(rst_n), .media_req(media_req),
      .media_lba(media_lba), .bad_lba(bad_lba), .bad_stat(bad_stat), .media_done(media_done),
      .media_stat(media_stat));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard, a full run takes about 3000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   // count fetches and note the first address asked for
   always @(posedge clk) begin
      if (media_done === 1'b1) begin
         if (nf == 0) lba0 = media_lba;
         lba1 = media_lba;
         nf++;
      end
   end
   task automatic chk_val(input logic [27:0] got, input logic [27:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp, input string msg);
      num_checks++;
      if (got != exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %0d want %0d", $time, msg, got, exp);
      end
   endtask
   task automatic wrap_up;
      if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic issue(input logic [7:0] code, input arssc_tf_type tf);
      @(negedge clk);
      nf = 0;
      cmd_wr = 1'b1;
      cmd_code = code;
      tf_in = tf;
      @(negedge clk);
      cmd_wr = 1'b0;
   endtask
   // host side: ack each interrupt, take whole sectors while drq
   task automatic serve;
      nd = 0;
      ni = 0;
      repeat (3000) begin
         if (intrq === 1'b1) begin
            ni++;
            status_rd = 1'b1;
         end
         @(negedge clk);
         status_rd = 1'b0;
         if (drq === 1'b1) begin
            nd++;
            word_rd = 1'b1;
            repeat (256) @(negedge clk);
            word_rd = 1'b0;
         end
         if (ni > 0 && bsy === 1'b0 && drq === 1'b0 && intrq === 1'b0) break;
      end
   endtask
   task automatic sense(input logic [7:0] ext);
      issue(8'h03, tf_in);
      status_rd = 1'b1;
      @(negedge clk);
      status_rd = 1'b0;
      chk_val(error_reg, ext, "sense code");
   endtask
   initial begin
      rst_n = 1'b0;
      {cmd_wr, word_rd, status_rd, cmd_code, tf_in} = '0;
      bad_lba = NB;
      bad_stat = ARSSC_MS_OK;
      {err_count, num_checks, nf, cyc} = '0;
      rows = '{
         '{8'h20, '{1'b1, 4'h0, 8'h00, 8'h00, 8'h10, 8'h02}, NB, ARSSC_MS_OK, 2, 2, 2, 1'b0, 8'h00, 8'h01},
         '{8'h40, '{1'b1, 4'h0, 8'h00, 8'h00, 8'h20, 8'h03}, NB, ARSSC_MS_OK, 3, 0, 1, 1'b0, 8'h00, 8'h01},
         '{8'h41, '{1'b1, 4'h0, 8'h00, 8'h00, 8'h20, 8'h03}, 28'h21, ARSSC_MS_UNCORR, 2, 0, 1, 1'b1, 8'h11, 8'h02},
         '{8'h20, '{1'b1, 4'h0, 8'h00, 8'h00, 8'h30, 8'h02}, 28'h30, ARSSC_MS_XFER, 1, 1, 1, 1'b1, 8'h1f, 8'h02},
         '{8'h21, '{1'b1, 4'h0, 8'h00, 8'h00, 8'h40, 8'h01}, 28'h40, ARSSC_MS_CORR, 1, 1, 1, 1'b0, 8'h18, 8'h01},
         '{8'h20, '{1'b1, 4'h0, 8'h00, 8'h00, 8'h50, 8'h01}, 28'h50, ARSSC_MS_SPARE, 1, 1, 1, 1'b1, 8'h3a, 8'h01},
         '{8'h21, '{1'b1, 4'h0, 8'h00, 8'h00, 8'h60, 8'h01}, 28'h60, ARSSC_MS_DIAG, 1, 1, 1, 1'b1, 8'h05, 8'h01},
         '{8'h13, '{1'b0, 4'h0, 8'h00, 8'h00, 8'h00, 8'h00}, NB, ARSSC_MS_OK, 0, 0, 1, 1'b0, 8'h00, 8'h00},
         '{8'h75, '{1'b1, 4'h1, 8'h00, 8'h00, 8'h00, 8'h00}, NB, ARSSC_MS_OK, 0, 0, 1, 1'b1, 8'h2f, 8'h00},
         '{8'h7a, '{1'b0, 4'h5, 8'h00, 8'h00, 8'h01, 8'h00}, NB, ARSSC_MS_OK, 0, 0, 1, 1'b1, 8'h21, 8'h00},
         '{8'h20, '{1'b0, 4'h1, 8'h00, 8'h00, 8'h02, 8'h01}, NB, ARSSC_MS_OK, 1, 1, 1, 1'b0, 8'h00, 8'h01},
         '{8'h21, '{1'b0, 4'h0, 8'h00, 8'h00, 8'h00, 8'h01}, NB, ARSSC_MS_OK, 0, 0, 1, 1'b1, 8'h21, 8'h01},
         '{8'h40, '{1'b0, 4'h3, 8'h00, 8'h00, 8'h10, 8'h02}, NB, ARSSC_MS_OK, 2, 0, 1, 1'b0, 8'h00, 8'h01},
         '{8'h70, '{1'b1, 4'h0, 8'h00, 8'h00, 8'h05, 8'h00}, NB, ARSSC_MS_OK, 0, 0, 1, 1'b0, 8'h00, 8'h00},
         '{8'h40, '{1'b1, 4'h0, 8'h00, 8'h10, 8'h00, 8'h01}, NB, ARSSC_MS_OK, 0, 0, 1, 1'b1, 8'h2f, 8'h01},
         '{8'h40, '{1'b1, 4'h0, 8'h00, 8'h01, 8'h00, 8'h00}, NB, ARSSC_MS_OK, 256, 0, 1, 1'b0, 8'h00, 8'h01}};
      repeat (3) @(negedge clk);
      chk_val({bsy, drq, intrq, err, media_req, error_reg}, 28'h0, "reset outputs");
      rst_n = 1'b1;
      foreach (rows[i]) begin
         bad_lba = rows[i].bad;
         bad_stat = rows[i].st;
         issue(rows[i].code, rows[i].tf);
         serve();
         chk_cnt(nf, rows[i].nf, "fetches");
         chk_cnt(nd, rows[i].nd, "sectors offered");
         chk_cnt(ni, rows[i].ni, "interrupts");
         chk_val(err, rows[i].er, "error flag");
         // chs rows all sit on cylinder zero
         exp_lba = rows[i].tf.lba_mode ? rows[i].tf[35:8] : 28'(rows[i].tf.head) * 28'h10
            + 28'(rows[i].tf.sec_num) - 28'h1;
         if (nf > 0) chk_val(lba0, exp_lba, "first address");
         if (nf > 0) chk_val(lba1, exp_lba + 28'(nf) - 28'h1, "last address");
         if (rows[i].code[7:4] == 4'h2 || rows[i].code[7:4] == 4'h4) begin
            chk_val(tf_out.sec_cnt, rows[i].cnt, "count left");
            if (rows[i].er) chk_val(tf_out.sec_num, (rows[i].st != ARSSC_MS_OK) ? rows[i].bad[7:0]
               : rows[i].tf.sec_num, "failing address");
         end
         sense(rows[i].ext);
      end
      // reset in mid verify, with a command refused while busy
      issue(8'h40, '{1'b1, 4'h0, 8'h00, 8'h00, 8'h00, 8'h00});
      repeat (40) @(negedge clk);
      chk_val(bsy, 1'b1, "busy in verify");
      issue(8'h13, tf_in);
      chk_val(intrq, 1'b0, "command while busy");
      rst_n = 1'b0;
      @(negedge clk);
      chk_val({bsy, media_req, intrq}, 28'h0, "second reset");
      rst_n = 1'b1;
      issue(rows[1].code, rows[1].tf);
      serve();
      chk_cnt(nf, 3, "verify after reset");
      wrap_up();
   end
endmodule
